// file: src/ldo_cfg_pkg.sv
// constants, types and helpers shared by the regulator output configuration register
package ldo_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map: the printed offset is an index, byte address is four times it
    localparam logic [31:0] REG_IDX_OUTPUT_SETTING  = 32'h0000_0006;
    localparam logic [31:0] REG_ADDR_OUTPUT_SETTING = REG_IDX_OUTPUT_SETTING << 2;

    // field layout of the 8-bit register
    localparam int          MODE_BIT_POS   = 7;
    localparam int          RSVD_BIT_POS   = 6;
    localparam int          VCODE_LSB      = 0;
    localparam int          VCODE_W        = 6;
    localparam int          REG_W          = 8;

    // mode encodings
    localparam logic        MODE_REGULATE  = 1'h0;
    localparam logic        MODE_SWITCH    = 1'h1;

    // value held before the programmed defaults are loaded
    localparam logic [5:0]  VCODE_RESET    = 6'h00;
    localparam logic        MODE_RESET     = MODE_REGULATE;

    ////////////////////////////////////////////////////////////////////////////////
    // voltage decode, voltage levels in millivolts, floor and ceiling thresholds as codes
    localparam int          MV_W           = 12;
    localparam logic [11:0] MV_FLOOR       = 12'h258;
    localparam logic [11:0] MV_STEP        = 12'h032;
    localparam logic [11:0] MV_MAX         = 12'hCE4;
    localparam logic [5:0]  VCODE_FLOOR    = 6'h02;
    localparam logic [5:0]  VCODE_CEIL     = 6'h38;

    ////////////////////////////////////////////////////////////////////////////////
    // bus encodings
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic        HRESP_OKAY     = 1'h0;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    // default number of synchroniser stages on the programmed-default inputs
    localparam int          SYNC_STAGES_DEF = 2;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       regulate_or_switch_select;
        logic [5:0] output_voltage_code;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{regulate_or_switch_select: MODE_RESET,
                                   output_voltage_code:       VCODE_RESET};

    typedef enum logic [1:0] {
        ST_FILL = 2'h0,
        ST_LOAD = 2'h1,
        ST_RUN  = 2'h3
    } load_state_t;

    // packs the configuration into the read-back word, reserved bit reads zero
    function automatic logic [31:0] cfg_to_word(input cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[MODE_BIT_POS] = c.regulate_or_switch_select;
        w[RSVD_BIT_POS] = 1'b0;
        w[VCODE_LSB +: VCODE_W] = c.output_voltage_code;
        return w;
    endfunction

    // unpacks a written word, reserved bit ignored
    function automatic cfg_t word_to_cfg(input logic [31:0] w);
        cfg_t c;
        c.regulate_or_switch_select = w[MODE_BIT_POS];
        c.output_voltage_code       = w[VCODE_LSB +: VCODE_W];
        return c;
    endfunction

    // address decode for the single mapped word
    function automatic logic is_reg_hit(input logic [31:0] addr);
        return addr == REG_ADDR_OUTPUT_SETTING;
    endfunction

endpackage

// file: src/voltage_code_decoder.sv
// decodes the 6-bit output voltage code into a millivolt target
`timescale 1ns/1ps
module voltage_code_decoder
    import ldo_cfg_pkg::*;
(
    input  wire logic [5:0]  code,
    output logic      [11:0] target_mv
);

    logic [5:0] steps;

    always_comb begin
        steps = 6'h00;
        if (code >= VCODE_CEIL) begin
            target_mv = MV_MAX;
        end else if (code <= VCODE_FLOOR) begin
            target_mv = MV_FLOOR;
        end else begin
            steps     = code - VCODE_FLOOR;
            target_mv = 12'(MV_FLOOR + MV_STEP * {6'h00, steps});
        end
    end

endmodule

// file: src/ldo_output_config_register.sv
// output configuration register of the second linear regulator, AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module ldo_output_config_register
    import ldo_cfg_pkg::*;
#(
    parameter int SYNC_STAGES = SYNC_STAGES_DEF
)(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,

    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,

    input  wire logic        NVM_MODE_DEFAULT,
    input  wire logic [5:0]  NVM_VCODE_DEFAULT,

    output logic             LOAD_SWITCH_OPERATION,
    output logic      [5:0]  OUTPUT_VOLTAGE_CODE,
    output logic      [11:0] TARGET_MV,
    output logic             CFG_LOADED
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    localparam int FILL_W = $clog2(SYNC_STAGES + 1);
    localparam logic [FILL_W-1:0] FILL_LAST = FILL_W'(SYNC_STAGES - 1);

    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state

    cfg_t [SYNC_STAGES-1:0] nvm_sync_q;
    cfg_t [SYNC_STAGES-1:0] nvm_sync_d;
    load_state_t            state_q;
    load_state_t            state_d;
    logic [FILL_W-1:0]      fill_q;
    logic [FILL_W-1:0]      fill_d;
    cfg_t                   cfg_q;
    cfg_t                   cfg_d;
    logic                   wr_pend_q;
    logic                   wr_pend_d;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;
    logic [11:0]            mv_q;
    logic [11:0]            mv_d;

    cfg_t                   nvm_pin;
    logic                   take;
    logic                   hit;
    logic [11:0]            dec_mv;

    ////////////////////////////////////////////////////////////////////////////////
    // bus address phase qualification

    assign nvm_pin.regulate_or_switch_select = NVM_MODE_DEFAULT;
    assign nvm_pin.output_voltage_code       = NVM_VCODE_DEFAULT;

    // bus ignores sizes: the only mapped word has all its bits in byte lane 0
    assign take = HSEL && (HTRANS == HTRANS_NONSEQ || HTRANS == 2'h3) && HREADY;
    assign hit  = is_reg_hit(HADDR);

    ////////////////////////////////////////////////////////////////////////////////
    // voltage decode

    voltage_code_decoder u_decoder (
        .code      (cfg_q.output_voltage_code),
        .target_mv (dec_mv)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // programmed-default synchroniser

    always_comb begin
        nvm_sync_d = {nvm_sync_q[SYNC_STAGES-2:0], nvm_pin};
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            nvm_sync_q <= '0;
        end else begin
            nvm_sync_q <= nvm_sync_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // load sequencer

    always_comb begin
        state_d = state_q;
        fill_d  = fill_q;

        case (state_q)
            ST_FILL: begin
                // defaults are only trusted once every synchroniser stage has refilled
                if (fill_q == FILL_LAST) begin
                    state_d = ST_LOAD;
                end else begin
                    fill_d = fill_q + FILL_W'(1);
                end
            end
            ST_LOAD: begin
                state_d = ST_RUN;
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                // an illegal code falls back to a full reload rather than locking the bus
                state_d = ST_FILL;
                fill_d  = '0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_FILL;
            fill_q  <= '0;
        end else begin
            state_q <= state_d;
            fill_q  <= fill_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration register

    always_comb begin
        cfg_d = cfg_q;

        case (state_q)
            ST_LOAD: begin
                cfg_d = nvm_sync_q[SYNC_STAGES-1];
            end
            ST_RUN: begin
                if (wr_pend_q) begin
                    cfg_d = word_to_cfg(HWDATA);
                end
            end
            default: begin
                cfg_d = cfg_q;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_q <= CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus data phase

    always_comb begin
        wr_pend_d = 1'b0;
        rdata_d   = rdata_q;

        if (take) begin
            wr_pend_d = HWRITE && hit;
            if (!HWRITE) begin
                // read of a word written in the previous data phase sees the new value
                rdata_d = hit ? cfg_to_word(cfg_d) : RDATA_UNMAPPED;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend_q <= 1'b0;
            rdata_q   <= RDATA_UNMAPPED;
        end else begin
            wr_pend_q <= wr_pend_d;
            rdata_q   <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decoded target, registered so the analog side never sees decode glitches

    always_comb begin
        mv_d = dec_mv;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mv_q <= MV_FLOOR;
        end else begin
            mv_q <= mv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // stalling until the defaults land keeps an early write from being overwritten
    assign HREADYOUT             = (state_q == ST_RUN);
    assign HRESP                 = HRESP_OKAY;
    assign HRDATA                = rdata_q;
    assign LOAD_SWITCH_OPERATION = cfg_q.regulate_or_switch_select;
    assign OUTPUT_VOLTAGE_CODE   = cfg_q.output_voltage_code;
    assign TARGET_MV             = mv_q;
    assign CFG_LOADED            = (state_q == ST_RUN);

endmodule

// file: bench/ldo_cfg_checker.sv
// concurrent checks on the output configuration register ports
`timescale 1ns/1ps
module ldo_cfg_checker
    import ldo_cfg_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST_B,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        NVM_MODE_DEFAULT,
    input wire logic [5:0]  NVM_VCODE_DEFAULT,
    input wire logic        LOAD_SWITCH_OPERATION,
    input wire logic [5:0]  OUTPUT_VOLTAGE_CODE,
    input wire logic [11:0] TARGET_MV,
    input wire logic        CFG_LOADED
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    logic [11:0] mv_e;
    wire logic   tk  = HSEL && HTRANS[1] && HREADY;
    wire logic   hit = HADDR == REG_ADDR_OUTPUT_SETTING;
    // expected decode kept one cycle late, as the output is registered
    always_ff @(posedge SYS_CLK) begin
        mv_e <= (OUTPUT_VOLTAGE_CODE <= VCODE_FLOOR) ? MV_FLOOR :
                (OUTPUT_VOLTAGE_CODE >= VCODE_CEIL) ? MV_MAX :
                MV_FLOOR + MV_STEP * (12'(OUTPUT_VOLTAGE_CODE) - 12'h002);
    end
    okay_resp_a: assert property (HRESP == HRESP_OKAY)
        else $error("response not okay");
    ready_loaded_a: assert property (HREADYOUT == CFG_LOADED)
        else $error("ready and loaded differ");
    load_time_a: assert property ($rose(RST_B) |->
        !CFG_LOADED ##1 !CFG_LOADED ##1 !CFG_LOADED ##1 CFG_LOADED)
        else $error("defaults not loaded on time");
    load_dflt_a: assert property ($rose(CFG_LOADED) |->
        {LOAD_SWITCH_OPERATION, OUTPUT_VOLTAGE_CODE} == {NVM_MODE_DEFAULT, NVM_VCODE_DEFAULT})
        else $error("defaults not loaded");
    wr_code_a: assert property (tk && HWRITE && hit |->
        ##2 OUTPUT_VOLTAGE_CODE == $past(HWDATA[5:0])) else $error("code not written");
    wr_mode_a: assert property (tk && HWRITE && hit |->
        ##2 LOAD_SWITCH_OPERATION == $past(HWDATA[7])) else $error("mode not written");
    rd_back_a: assert property (tk && !HWRITE && hit |=>
        HRDATA == {24'h000000, LOAD_SWITCH_OPERATION, 1'b0, OUTPUT_VOLTAGE_CODE})
        else $error("read data wrong");
    rd_unmap_a: assert property (tk && !HWRITE && !hit |=> HRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    mv_decode_a: assert property (CFG_LOADED && $past(CFG_LOADED) |->
        TARGET_MV == mv_e) else $error("voltage decode wrong");
    cover property (tk && HWRITE && hit);
    cover property (tk && !HWRITE && !hit);
    cover property (CFG_LOADED && OUTPUT_VOLTAGE_CODE == 6'h3F);
endmodule

bind ldo_output_config_register ldo_cfg_checker u_chk (.*);

// file: bench/ahb_host.sv
// bus host issuing single-word transfers to the register
`timescale 1ns/1ps
module ahb_host (
    input  wire logic        clk,
    input  wire logic        HREADY,
    input  wire logic [31:0] HRDATA,
    output logic             HSEL,
    output logic      [31:0] HADDR,
    output logic      [1:0]  HTRANS,
    output logic             HWRITE,
    output logic      [2:0]  HSIZE,
    output logic      [31:0] HWDATA
);
    initial begin
        {HSEL, HADDR, HTRANS, HWRITE, HWDATA} = '0;
        HSIZE = 3'h2;
    end
    // mode bit only rewritten while the rail is off: no rail enable here
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge clk);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= a;
        HWDATA <= ~HWDATA;
        // ready sampled at the edge itself: the slave only moves it after that edge
        do @(posedge clk); while (HREADY !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        HADDR <= ~a;
        do @(posedge clk); while (HREADY !== 1'b1);
        r = HRDATA;
    endtask
endmodule

// file: bench/tb_top.sv
// self-checking bench for the output configuration register
`timescale 1ns/1ps
module tb_top
    import ldo_cfg_pkg::*;
;
    logic        SYS_CLK = 1'b0;
    logic        RST_B = 1'b0;
    logic        NVM_MODE_DEFAULT = 1'b0;
    logic [5:0]  NVM_VCODE_DEFAULT = 6'h00;
    logic        HSEL, HWRITE, HREADYOUT, HRESP, LOAD_SWITCH_OPERATION, CFG_LOADED;
    logic [31:0] HADDR, HWDATA, HRDATA, rd, d, m;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic [5:0]  OUTPUT_VOLTAGE_CODE;
    logic [11:0] TARGET_MV;
    wire logic   HREADY = HREADYOUT;
    int          error_cnt = 0, num_checks = 0, cyc = 0, c;

    ldo_output_config_register u_dut (.*);
    ahb_host u_host (.clk(SYS_CLK), .*);

    initial forever #50 SYS_CLK = ~SYS_CLK;

    function automatic int mvf(int k);
        return k <= 2 ? 32'h258 : k >= 32'h38 ? 32'hCE4 : 32'h258 + 32'h32 * (k - 2);
    endfunction

    task automatic chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic do_reset;
        @(posedge SYS_CLK);
        RST_B <= 1'b0;
        NVM_MODE_DEFAULT <= 1'($urandom);
        NVM_VCODE_DEFAULT <= 6'($urandom);
        repeat (16) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        for (int i = 0; i < 10 && CFG_LOADED !== 1'b1; i++) @(negedge SYS_CLK);
        u_host.xfer(1'b0, REG_ADDR_OUTPUT_SETTING, 32'h0, rd);
        m = 32'({NVM_MODE_DEFAULT, 1'b0, NVM_VCODE_DEFAULT});
        chk(rd, m);
    endtask

    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(1261));
        do_reset();
        // every code, random upper bits to prove all but the mode bit are dropped
        for (c = 0; c < 64; c++) begin
            d = $urandom;
            d[5:0] = 6'(c);
            u_host.xfer(1'b1, REG_ADDR_OUTPUT_SETTING, d, rd);
            u_host.xfer(1'b0, REG_ADDR_OUTPUT_SETTING, 32'h0, rd);
            m = 32'({d[7], 1'b0, d[5:0]});
            chk(rd, m);
            chk(32'(LOAD_SWITCH_OPERATION), 32'(d[7]));
            repeat (2) @(negedge SYS_CLK);
            chk(32'(TARGET_MV), mvf(c));
        end
        u_host.xfer(1'b1, REG_ADDR_OUTPUT_SETTING + 4, 32'h0000_00BF, rd);
        u_host.xfer(1'b0, REG_ADDR_OUTPUT_SETTING + 4, 32'h0, rd);
        chk(rd, 32'h0);
        u_host.xfer(1'b0, REG_ADDR_OUTPUT_SETTING, 32'h0, rd);
        chk(rd, m);
        do_reset();
        give_verdict();
    end
endmodule
